/* File: core/trc_pkg.sv */
package trc_pkg;
    localparam logic [7:0] OP_NOP       = 8'h00;
    localparam logic [7:0] OP_MEM_WR    = 8'h01;
    localparam logic [7:0] OP_MEM_RD    = 8'h02;
    localparam logic [7:0] OP_CKSUM     = 8'h03;
    localparam logic [7:0] OP_ROLE_A    = 8'h04;
    localparam logic [7:0] OP_ROLE_B    = 8'h05;
    localparam logic [7:0] OP_TEST_OBS  = 8'h06;
    localparam logic [7:0] OP_PERS_LOAD = 8'h07;
    localparam logic [7:0] OP_PERS_FLAG = 8'h08;
    localparam logic [7:0] OP_FMT_NAT   = 8'h09;
    localparam logic [7:0] OP_FMT_OLD   = 8'h0A;
    localparam logic [7:0] OP_ECHO      = 8'h0B;
    localparam logic [7:0] OP_SRC_TEST  = 8'h0C;
    localparam logic [7:0] OP_SRC_TAPE  = 8'h0D;
    localparam logic [7:0] OP_TRK_MIX   = 8'h10;
    localparam logic [7:0] OP_TRK_ASGN  = 8'h11;
    localparam logic [7:0] OP_OBS_PARM  = 8'h12;
    localparam logic [7:0] OP_FRAME_DUR = 8'h13;
    localparam logic [7:0] OP_OBS_GO    = 8'h14;
    localparam logic [7:0] OP_DATA_INV  = 8'h15;
    localparam logic [7:0] OP_AUTO_VAL  = 8'h16;
    localparam logic [7:0] OP_OBS_END   = 8'h17;
    localparam logic [7:0] OP_HDR_READ  = 8'h19;

    localparam int          PERS_XFERS    = 15;
    localparam int          PERS_XFER_LEN = 1910;
    localparam logic [14:0] PERS_LAST     =
        15'(PERS_XFERS * PERS_XFER_LEN - 1);
    localparam logic [4:0]  HDR_LAST      = 5'd23;
    localparam logic [3:0]  HDR_SYS_TRACK = 4'h8;
    localparam logic [7:0]  SS_ALL_OFF    = 8'h00;
    localparam logic [7:0]  SS_NO_SUB     = 8'hFF;
    localparam int          FMT_BIT       = 56;

    localparam logic [7:0] REG_TX   = 8'h00;
    localparam logic [7:0] REG_RX   = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int ST_TX_BUSY = 0;
    localparam int ST_RX_VAL  = 1;
    localparam int ST_RX_OVR  = 2;
    localparam int ST_ID_DONE = 3;

    // Number of argument bytes after each operation code
    function automatic logic [3:0] trc_arg_len(input logic [7:0] op);
        case (op)
            OP_MEM_WR, OP_MEM_RD, OP_CKSUM: trc_arg_len = 4'd6;
            OP_ECHO, OP_HDR_READ:           trc_arg_len = 4'd1;
            OP_TRK_MIX:                     trc_arg_len = 4'd3;
            OP_TRK_ASGN:                    trc_arg_len = 4'd5;
            OP_OBS_PARM:                    trc_arg_len = 4'd8;
            OP_FRAME_DUR:                   trc_arg_len = 4'd2;
            default:                        trc_arg_len = 4'd0;
        endcase
    endfunction
endpackage

/* File: core/trc_link_if.sv */
`timescale 1ns/1ps
interface trc_link_if;
    logic [7:0] cmd_data;
    logic       cmd_valid;
    logic       cmd_ready;
    logic [7:0] rsp_data;
    logic       rsp_valid;

    modport dev (input cmd_data, input cmd_valid, output cmd_ready,
                 output rsp_data, output rsp_valid);
    modport ctl (output cmd_data, output cmd_valid, input cmd_ready,
                 input rsp_data, input rsp_valid);
endinterface

/* File: core/trc_dev.sv */
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module trc_dev #(
    parameter int MEM_AW = 16
) (
    input  wire logic        clk_sys_i,        // System clock
    input  wire logic        rst_i,            // Async reset, high
    trc_link_if.dev          link,             // Link to controller
    input  wire logic        cfg_ok_first_i,   // First load succeeded
    input  wire logic        cfg_ok_second_i,  // Second load succeeded
    input  wire logic [7:0]  hdr_byte_i,       // Header byte at hdr_idx_o
    output logic             role_a_o,         // First processor role
    output logic             role_b_o,         // Second processor role
    output logic             fmt_native_o,     // Native tape format
    output logic             src_test_o,       // Test frame source
    output logic             test_obs_o,       // Test observation pulse
    output logic             observing_o,      // Observing mode
    output logic             data_invalid_o,   // Data forced invalid
    output logic [1:0]       sys_track_sel_o,  // System track select
    output logic [15:0]      drive_sel_o,      // Drive track per channel
    output logic             sys_en_o,         // System track enabled
    output logic [7:0]       sys_sub_o,        // Substituted inputs
    output logic [7:0]       trk_active_o,     // Input active
    output logic [7:0]       val_even_o,       // Validity to even chan
    output logic [7:0]       val_odd_o,        // Validity to odd chan
    output logic [7:0]       pers_data_o,      // Personality byte
    output logic             pers_valid_o,     // Personality strobe
    output logic [3:0]       hdr_track_o,      // Header track select
    output logic [4:0]       hdr_idx_o         // Header byte index
);
    typedef enum logic [3:0] {
        S_IDLE, S_ARGS, S_WR, S_RD, S_CK, S_CK_HI, S_CK_LO, S_PERS, S_HDR
    } trc_state_t;

    trc_state_t  state;
    logic [7:0]  mem [0:(2**MEM_AW)-1];
    logic [7:0]  op;
    logic [3:0]  arg_left;
    logic [63:0] args;
    logic [63:0] next_args;
    logic [15:0] addr;
    logic [15:0] cnt;
    logic [15:0] sum;
    logic [14:0] pers_cnt;
    logic [7:0]  rsp_data;
    logic        rsp_valid;
    logic        take;
    logic        zero_go;
    logic        args_go;
    logic        exec;
    logic [7:0]  exec_op;
    logic [7:0]  ss;

    assign link.cmd_ready = (state == S_IDLE) || (state == S_ARGS) ||
                            (state == S_WR) || (state == S_PERS);
    assign link.rsp_data  = rsp_data;
    assign link.rsp_valid = rsp_valid;
    assign take      = link.cmd_valid && link.cmd_ready;
    assign next_args = {args[55:0], link.cmd_data};
    assign zero_go   = (state == S_IDLE) && take &&
                       (trc_pkg::trc_arg_len(link.cmd_data) == 4'h0);
    assign args_go   = (state == S_ARGS) && take && (arg_left == 4'h1);
    assign exec      = zero_go || args_go;
    assign exec_op   = zero_go ? link.cmd_data : op;
    assign ss        = next_args[39:32];

    // Byte store for memory writes
    always_ff @(posedge clk_sys_i) begin
        if (state == S_WR && take) begin
            mem[addr[MEM_AW-1:0]] <= link.cmd_data;
        end
    end

    // Command sequencing and replies
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state     <= S_IDLE;
            op        <= 8'h00;
            arg_left  <= 4'h0;
            args      <= 64'h0;
            addr      <= 16'h0000;
            cnt       <= 16'h0000;
            sum       <= 16'h0000;
            pers_cnt  <= 15'h0000;
            rsp_data  <= 8'h00;
            rsp_valid <= 1'b0;
            pers_data_o  <= 8'h00;
            pers_valid_o <= 1'b0;
            hdr_track_o  <= 4'h0;
            hdr_idx_o    <= 5'h00;
        end else begin
            rsp_valid    <= 1'b0;
            pers_valid_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (take && !zero_go) begin
                        op       <= link.cmd_data;
                        arg_left <= trc_pkg::trc_arg_len(link.cmd_data);
                        state    <= S_ARGS;
                    end
                end
                S_ARGS: begin
                    if (take) begin
                        args     <= next_args;
                        arg_left <= arg_left - 4'h1;
                    end
                end
                S_WR: begin
                    if (take) begin
                        addr <= addr + 16'h0001;
                        cnt  <= cnt - 16'h0001;
                        if (cnt == 16'h0001) state <= S_IDLE;
                    end
                end
                S_RD: begin
                    rsp_data  <= mem[addr[MEM_AW-1:0]];
                    rsp_valid <= 1'b1;
                    addr      <= addr + 16'h0001;
                    cnt       <= cnt - 16'h0001;
                    if (cnt == 16'h0001) state <= S_IDLE;
                end
                S_CK: begin
                    sum  <= sum + {8'h00, mem[addr[MEM_AW-1:0]]};
                    addr <= addr + 16'h0001;
                    cnt  <= cnt - 16'h0001;
                    if (cnt == 16'h0001) state <= S_CK_HI;
                end
                S_CK_HI: begin
                    rsp_data  <= sum[15:8];
                    rsp_valid <= 1'b1;
                    state     <= S_CK_LO;
                end
                S_CK_LO: begin
                    rsp_data  <= sum[7:0];
                    rsp_valid <= 1'b1;
                    state     <= S_IDLE;
                end
                S_PERS: begin
                    if (take) begin
                        pers_data_o  <= link.cmd_data;
                        pers_valid_o <= 1'b1;
                        pers_cnt     <= pers_cnt + 15'h0001;
                        if (pers_cnt == trc_pkg::PERS_LAST) state <= S_IDLE;
                    end
                end
                S_HDR: begin
                    rsp_data  <= hdr_byte_i;
                    rsp_valid <= 1'b1;
                    hdr_idx_o <= hdr_idx_o + 5'h01;
                    if (hdr_idx_o == trc_pkg::HDR_LAST) state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            // Same action whether the code takes no arguments or its last argument just arrived
            if (exec) begin
                if (args_go) state <= S_IDLE;
                case (exec_op)
                    trc_pkg::OP_MEM_WR, trc_pkg::OP_MEM_RD,
                    trc_pkg::OP_CKSUM: begin
                        addr <= next_args[31:16];
                        cnt  <= next_args[15:0];
                        sum  <= 16'h0000;
                        if (next_args[15:0] == 16'h0000) begin
                            state <= (op == trc_pkg::OP_CKSUM) ?
                                     S_CK_HI : S_IDLE;
                        end else if (op == trc_pkg::OP_MEM_WR) begin
                            state <= S_WR;
                        end else if (op == trc_pkg::OP_MEM_RD) begin
                            state <= S_RD;
                        end else begin
                            state <= S_CK;
                        end
                    end
                    trc_pkg::OP_PERS_LOAD: begin
                        if (role_b_o) begin
                            pers_cnt <= 15'h0000;
                            state    <= S_PERS;
                        end
                    end
                    trc_pkg::OP_PERS_FLAG: begin
                        rsp_data  <= {6'h00, cfg_ok_second_i,
                                      cfg_ok_first_i};
                        rsp_valid <= 1'b1;
                    end
                    trc_pkg::OP_ECHO: begin
                        rsp_data  <= next_args[7:0];
                        rsp_valid <= 1'b1;
                    end
                    trc_pkg::OP_HDR_READ: begin
                        hdr_track_o <= next_args[3:0];
                        hdr_idx_o   <= 5'h00;
                        state       <= S_HDR;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Mode and configuration registers; unlisted codes fall through
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            role_a_o        <= 1'b0;
            role_b_o        <= 1'b0;
            fmt_native_o    <= 1'b1;
            src_test_o      <= 1'b0;
            test_obs_o      <= 1'b0;
            observing_o     <= 1'b0;
            data_invalid_o  <= 1'b0;
            sys_track_sel_o <= 2'h0;
            drive_sel_o     <= 16'h0000;
            sys_en_o        <= 1'b0;
            sys_sub_o       <= 8'h00;
            trk_active_o    <= 8'h00;
            val_even_o      <= 8'h00;
            val_odd_o       <= 8'h00;
        end else begin
            test_obs_o <= 1'b0;
            if (exec) begin
                case (exec_op)
                    trc_pkg::OP_ROLE_A: begin
                        role_a_o <= 1'b1;
                        role_b_o <= 1'b0;
                    end
                    trc_pkg::OP_ROLE_B: begin
                        role_a_o <= 1'b0;
                        role_b_o <= 1'b1;
                    end
                    trc_pkg::OP_TEST_OBS: test_obs_o <= 1'b1;
                    trc_pkg::OP_FMT_NAT: fmt_native_o <= 1'b1;
                    trc_pkg::OP_FMT_OLD: fmt_native_o <= 1'b0;
                    trc_pkg::OP_OBS_PARM:
                        fmt_native_o <= next_args[trc_pkg::FMT_BIT];
                    trc_pkg::OP_SRC_TEST:
                        if (role_a_o) src_test_o <= 1'b1;
                    trc_pkg::OP_SRC_TAPE:
                        if (role_a_o) src_test_o <= 1'b0;
                    trc_pkg::OP_TRK_MIX: begin
                        sys_track_sel_o <= next_args[17:16];
                        drive_sel_o     <= next_args[15:0];
                    end
                    trc_pkg::OP_TRK_ASGN: begin
                        sys_en_o  <= (ss != trc_pkg::SS_ALL_OFF);
                        sys_sub_o <= (ss == trc_pkg::SS_NO_SUB) ? 8'h00 : ss;
                        // Nibble 4i+2..4i drives input i
                        for (int i = 0; i < 8; i++) begin
                            trk_active_o[i] <= |next_args[4*i+:3];
                            val_even_o[i]   <= next_args[4*i] &
                                               ~next_args[4*i+2];
                            val_odd_o[i]    <= next_args[4*i+1] &
                                               ~next_args[4*i+2];
                        end
                    end
                    trc_pkg::OP_OBS_GO: begin
                        observing_o    <= 1'b1;
                        data_invalid_o <= 1'b0;
                    end
                    trc_pkg::OP_DATA_INV:
                        if (observing_o) data_invalid_o <= 1'b1;
                    trc_pkg::OP_AUTO_VAL: data_invalid_o <= 1'b0;
                    trc_pkg::OP_OBS_END: begin
                        observing_o    <= 1'b0;
                        data_invalid_o <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

/* File: core/trc_ctl.sv */
`timescale 1ns/1ps
module trc_ctl #(
    parameter bit ROLE_B = 1'b0
) (
    input  wire logic        clk_sys_i,  // System clock
    input  wire logic        rst_i,      // Async reset, high
    trc_link_if.ctl          link,       // Link to device
    input  wire logic [7:0]  addr_i,     // Register byte address
    input  wire logic [7:0]  wdata_i,    // Write data
    input  wire logic        wr_i,       // Write strobe
    input  wire logic        rd_i,       // Read strobe
    output logic [7:0]       rdata_o     // Read data, cycle after rd_i
);
    logic [7:0] out_byte;
    logic       out_valid;
    logic       id_done;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_ovr;
    logic       sent;
    logic       rx_rd;

    assign link.cmd_data  = out_byte;
    assign link.cmd_valid = out_valid;
    assign sent  = out_valid && link.cmd_ready;
    assign rx_rd = rd_i && (addr_i == trc_pkg::REG_RX);

    // Outgoing byte; identity goes first after reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            out_byte  <= ROLE_B ? trc_pkg::OP_ROLE_B
                                : trc_pkg::OP_ROLE_A;
            out_valid <= 1'b1;
            id_done   <= 1'b0;
        end else begin
            if (sent) begin
                out_valid <= 1'b0;
                id_done   <= 1'b1;
            end
            if (wr_i && addr_i == trc_pkg::REG_TX && !out_valid) begin
                out_byte  <= wdata_i;
                out_valid <= 1'b1;
            end
        end
    end

    // Reply capture; a new byte wins over a clearing read
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
            rx_ovr   <= 1'b0;
        end else begin
            if (rx_rd) begin
                rx_valid <= 1'b0;
            end
            if (wr_i && addr_i == trc_pkg::REG_STAT &&
                wdata_i[trc_pkg::ST_RX_OVR]) begin
                rx_ovr <= 1'b0;
            end
            if (link.rsp_valid) begin
                rx_byte  <= link.rsp_data;
                rx_valid <= 1'b1;
                if (rx_valid && !rx_rd) begin
                    rx_ovr <= 1'b1;
                end
            end
        end
    end

    // Register read port
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (addr_i == trc_pkg::REG_RX) begin
                rdata_o <= rx_byte;
            end else if (addr_i == trc_pkg::REG_STAT) begin
                rdata_o <= {4'h0, id_done, rx_ovr, rx_valid, out_valid};
            end else begin
                rdata_o <= 8'h00;
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule

/* File: test/trc_link_props.sv */
`timescale 1ns/1ps
module trc_link_props (
    input  wire logic       clk_sys_i, // System clock
    input  wire logic       rst_i,     // Async reset, high
    input  wire logic [7:0] cmd_data,  // Command byte
    input  wire logic       cmd_valid, // Byte offered
    input  wire logic       cmd_ready, // Byte accepted
    input  wire logic [7:0] rsp_data,  // Reply byte
    input  wire logic       rsp_valid  // Reply strobe
);
    logic        tk;
    logic        idle;
    logic        last;
    logic [7:0]  op;
    logic [7:0]  prev;
    logic [3:0]  left;
    logic [3:0]  alen;
    logic [15:0] dleft;
    logic [15:0] cnt_now;

    // Command framing tracker
    assign tk      = cmd_valid && cmd_ready;
    assign idle    = (left == 4'h0) && (dleft == 16'h0000);
    assign last    = tk && (left == 4'h1);
    assign cnt_now = {prev, cmd_data};
    always_comb begin
        case (cmd_data)
            8'h01, 8'h02, 8'h03: alen = 4'h6;
            8'h0B, 8'h19:        alen = 4'h1;
            8'h10:               alen = 4'h3;
            8'h11:               alen = 4'h5;
            8'h12:               alen = 4'h8;
            8'h13:               alen = 4'h2;
            default:             alen = 4'h0;
        endcase
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            op    <= 8'h00;
            prev  <= 8'h00;
            left  <= 4'h0;
            dleft <= 16'h0000;
        end else if (tk) begin
            prev <= cmd_data;
            if (idle) begin
                op   <= cmd_data;
                left <= alen;
            end else if (left != 4'h0) begin
                left <= left - 4'h1;
                if (left == 4'h1 && op == 8'h01) begin
                    dleft <= cnt_now;
                end
            end else begin
                dleft <= dleft - 16'h0001;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_id_after_reset: assert property ($fell(rst_i) |->
        cmd_valid && cmd_data == 8'h04) else $error("identity byte missing");
    a_req_held: assert property (cmd_valid && !cmd_ready |=>
        cmd_valid && $stable(cmd_data)) else $error("request not held");
    a_echo_returns: assert property (last && op == 8'h0B |=>
        rsp_valid && rsp_data == $past(cmd_data)) else $error("bad echo");
    a_flag_one_byte: assert property (tk && idle && cmd_data == 8'h08 |=>
        rsp_valid && rsp_data[7:2] == 6'h00 ##1 !rsp_valid)
        else $error("bad flag reply");
    a_read_starts: assert property (last && op == 8'h02 &&
        cnt_now != 16'h0000 |=> !cmd_ready ##1 rsp_valid)
        else $error("read reply late");
    a_cksum_empty: assert property (last && op == 8'h03 &&
        cnt_now == 16'h0000 |-> ##[1:3] (rsp_valid && rsp_data == 8'h00)
        ##1 (rsp_valid && rsp_data == 8'h00)) else $error("bad checksum");
    a_hdr_length: assert property (last && op == 8'h19 |=>
        ##1 rsp_valid [*8] ##16 rsp_valid ##1 !rsp_valid)
        else $error("header reply not 24 bytes");
    a_ignored_silent: assert property (tk && idle &&
        cmd_data inside {8'h00, 8'h18, [8'h1A:8'h1F]} |=> !rsp_valid [*2])
        else $error("reply to ignored code");

    c_read: cover property (last && op == 8'h02);
    c_header: cover property (last && op == 8'h19);
    c_flag: cover property (tk && idle && cmd_data == 8'h08);
endmodule

/* File: test/tb_track_recovery_command_set.sv */
`timescale 1ns/1ps
module tb_track_recovery_command_set;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0;
    logic ok_a = 1'b0, ok_b = 1'b0, role_a, fmt, src, tobs, obs, dinv, en;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx, sub, act, ev, od;
    logic [15:0] drv;
    logic [1:0]  sts;
    logic [3:0]  trk;
    logic [4:0]  idx;
    logic        role_b;
    int error_cnt = 0, checked = 0, pulses = 0;

    trc_link_if trc_link_if_inst ();
    trc_dev #(.MEM_AW(8)) trc_dev_inst (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .link(trc_link_if_inst.dev), .cfg_ok_first_i(ok_a),
        .cfg_ok_second_i(ok_b), .hdr_byte_i({trk[2:0], idx}),
        .role_a_o(role_a), .role_b_o(role_b), .fmt_native_o(fmt),
        .src_test_o(src),
        .test_obs_o(tobs), .observing_o(obs), .data_invalid_o(dinv),
        .sys_track_sel_o(sts), .drive_sel_o(drv), .sys_en_o(en),
        .sys_sub_o(sub), .trk_active_o(act), .val_even_o(ev),
        .val_odd_o(od), .pers_data_o(), .pers_valid_o(),
        .hdr_track_o(trk), .hdr_idx_o(idx));
    trc_ctl trc_ctl_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .link(trc_link_if_inst.ctl), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
    trc_link_props trc_link_props_inst (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .cmd_data(trc_link_if_inst.cmd_data),
        .cmd_valid(trc_link_if_inst.cmd_valid),
        .cmd_ready(trc_link_if_inst.cmd_ready),
        .rsp_data(trc_link_if_inst.rsp_data),
        .rsp_valid(trc_link_if_inst.rsp_valid));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (tobs === 1'b1) pulses++;

    task automatic chk(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // One strobe cycle; read data captured after the following edge
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk_sys_i);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rx = rdata;
    endtask
    task automatic wait_stat(input int b, input logic v);
        bus(1'b0, 8'h08, 8'h00);
        for (int n = 0; n < 60 && rx[b] !== v; n++) bus(1'b0, 8'h08, 8'h00);
        chk("status bit", {15'h0000, rx[b]}, {15'h0000, v});
    endtask
    task automatic cmd(input int n, input logic [63:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            wait_stat(0, 1'b0);
            bus(1'b1, 8'h00, v[8*i+:8]);
        end
        wait_stat(0, 1'b0);
        // Long enough for a full header reply to land
        repeat (28) @(posedge clk_sys_i);
    endtask
    task automatic reply(input logic [7:0] e, input string n);
        wait_stat(1, 1'b1);
        bus(1'b0, 8'h04, 8'h00);
        chk(n, {8'h00, rx}, {8'h00, e});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys_i);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        wait_stat(3, 1'b1);
        chk("role", {14'h0000, role_b, role_a}, 16'h0001);
        cmd(7, 64'h0001000000100003);
        cmd(3, 64'h0000000000A1B2C3);
        for (int i = 0; i < 3; i++) begin
            cmd(7, {8'h00, 8'h02, 32'h00000010 + i, 16'h0001});
            reply(8'(8'hA1 + 8'h11 * i), "stored byte");
        end
        cmd(7, 64'h0003000000100003);
        reply(8'h16, "checksum low");
        bus(1'b0, 8'h08, 8'h00);
        chk("overrun", {15'h0000, rx[2]}, 16'h0001);
        bus(1'b1, 8'h08, 8'h04);
        bus(1'b0, 8'h08, 8'h00);
        chk("overrun clear", {15'h0000, rx[2]}, 16'h0000);
        cmd(7, 64'h0003000000100000);
        reply(8'h00, "empty checksum");
        $display("memory test done");
        for (int i = 0; i < 4; i++) begin
            cmd(2, {48'h0, 8'h0B, 8'(i * 90)});
            reply(8'(i * 90), "echo");
            ok_a <= i[0];
            ok_b <= i[1];
            cmd(1, 64'h08);
            reply(8'(i), "load flag");
        end
        cmd(1, 64'h07);
        cmd(2, 64'h0B5A);
        reply(8'h5A, "echo after load");
        cmd(1, 64'h0A);
        chk("native format", {15'h0000, fmt}, 16'h0000);
        cmd(1, 64'h09);
        chk("native format", {15'h0000, fmt}, 16'h0001);
        cmd(1, 64'h0C);
        chk("test source", {15'h0000, src}, 16'h0001);
        cmd(1, 64'h0D);
        chk("test source", {15'h0000, src}, 16'h0000);
        cmd(4, 64'h1003A53C);
        chk("system track", {14'h0000, sts}, 16'h0003);
        chk("drive select", drv, 16'hA53C);
        cmd(6, 64'h118001234010);
        chk("active", {8'h00, act}, 16'h007A);
        chk("even", {8'h00, ev}, 16'h0052);
        chk("odd", {8'h00, od}, 16'h0030);
        chk("substitute", {8'h00, sub}, 16'h0080);
        cmd(6, 64'h11FF00000000);
        chk("sys on", {7'h00, en, sub}, 16'h0100);
        cmd(6, 64'h110000000000);
        chk("sys off", {7'h00, en, act}, 16'h0000);
        $display("setup test done");
        cmd(1, 64'h14);
        chk("observing", {15'h0000, obs}, 16'h0001);
        cmd(1, 64'h15);
        chk("invalid", {15'h0000, dinv}, 16'h0001);
        cmd(1, 64'h16);
        chk("invalid", {15'h0000, dinv}, 16'h0000);
        cmd(1, 64'h17);
        chk("observing", {15'h0000, obs}, 16'h0000);
        cmd(1, 64'h06);
        chk("test pulses", 16'(pulses), 16'h0001);
        cmd(3, 64'h00181F);
        bus(1'b0, 8'h08, 8'h00);
        chk("no reply", {15'h0000, rx[1]}, 16'h0000);
        cmd(2, 64'h1905);
        reply(8'hB7, "header last");
        cmd(2, 64'h1908);
        reply(8'h17, "system header");
        chk("header track", {12'h000, trk}, 16'h0008);
        $display("observe test done");
        tally_and_finish();
    end
endmodule
